// >>> design/ebac_pkg.sv
package ebac_pkg;

	// store geometry
	localparam int unsigned NVM_DEPTH = 64;
	localparam int unsigned NVM_AW    = 6;
	localparam int unsigned NVM_DW    = 8;

	// directly mapped special function addresses, sector 0
	localparam logic [7:0] ADDR_INDIRECT1   = 8'h01;
	localparam logic [7:0] ADDR_PTR1_LOW    = 8'h02;
	localparam logic [7:0] ADDR_PTR1_HIGH   = 8'h03;
	localparam logic [7:0] ADDR_INDIRECT2   = 8'h04;
	localparam logic [7:0] ADDR_PTR2_LOW    = 8'h05;
	localparam logic [7:0] ADDR_PTR2_HIGH   = 8'h06;
	localparam logic [7:0] ADDR_NVM_ADDRESS = 8'h2C;
	localparam logic [7:0] ADDR_NVM_DATA    = 8'h2D;

	// control register location, reached only through a pointer pair
	localparam logic [7:0] CTRL_LOW_ADDR = 8'h40;
	localparam logic [7:0] CTRL_SECTOR   = 8'h01;

	// control register bit positions
	localparam int unsigned CTRL_FETCH_BIT    = 0;
	localparam int unsigned CTRL_FETCH_EN_BIT = 1;
	localparam int unsigned CTRL_PROG_BIT     = 2;
	localparam int unsigned CTRL_PROG_EN_BIT  = 3;

	// values after reset
	localparam logic [7:0]        RST_BYTE = 8'h00;
	localparam logic [NVM_AW-1:0] RST_ADDR = 6'h00;
	localparam logic [7:0]        RST_CNT  = 8'h00;

	// cycle counts
	localparam logic [7:0] READ_CYCLES_DEF = 8'h04;
	localparam logic [7:0] WRITE_TICKS_DEF = 8'h08;
	localparam logic [7:0] TICK_DIV_DEF    = 8'h10;

	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_READ  = 2'b01,
		ST_WRITE = 2'b10
	} ebac_state_type;

	// one access from the core to a sector 0 special function address
	typedef struct packed {
		logic [7:0] addr;
		logic       wr;
		logic       rd;
		logic [7:0] wdata;
	} ebac_req_type;

	// interrupt controller side levels and pulses
	typedef struct packed {
		logic global_irq_enable;
		logic mf_irq_enable;
		logic nvm_irq_enable;
		logic stack_full;
		logic mf_irq_service;
		logic nvm_irq_flag_clr;
	} ebac_irq_ctl_type;

endpackage : ebac_pkg

// >>> design/ebac_slow_timer.sv
`timescale 1ns/100ps
// free-running slow reference, brought into clk through a two-flop synchroniser
module ebac_slow_timer #(
	parameter logic [7:0] TICK_DIV = ebac_pkg::TICK_DIV_DEF
) (
	input  wire logic clk,
	input  wire logic sys_rst,
	output logic      tick
);

	logic [7:0] div_r;
	logic       ref_r;
	logic       sync1_r;
	logic       sync2_r;
	logic       sync3_r;

	// the reference runs regardless of any cycle, so a write starts at an arbitrary phase
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			div_r <= ebac_pkg::RST_CNT;
			ref_r <= 1'b0;
		end else if (div_r == TICK_DIV - 8'h01) begin
			div_r <= ebac_pkg::RST_CNT;
			ref_r <= ~ref_r;
		end else begin
			div_r <= div_r + 8'h01;
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			sync1_r <= 1'b0;
			sync2_r <= 1'b0;
			sync3_r <= 1'b0;
		end else begin
			sync1_r <= ref_r;
			sync2_r <= sync1_r;
			sync3_r <= sync2_r;
		end
	end

	// each edge of the reference is one tick
	assign tick = sync2_r ^ sync3_r;

endmodule : ebac_slow_timer

// >>> design/ebac_top.sv
`timescale 1ns/100ps
// Behaviour
// - store holds 64 bytes, read and written one byte at a time.
// - six-bit store address; upper two address bits read as zero.
// - control register only at 40H sector 1, via pointer and indirect port.
// - write strobe starts a write only if program enable already set.
// - write strobe clears itself when the write cycle completes.
// - read strobe starts a read only if fetch enable already set.
// - read strobe clears itself at read end; byte then valid in data register.
// - program enable zero blocks every write cycle.
// - fetch enable zero blocks every read cycle.
// - data register keeps fetched byte until next read or write.
// - write cycle timed by slow timer asynchronous to system clock; here the timer is divided down from clk.
// - reset clears program enable.
// - reset clears pointer high bytes, selecting sector 0.
// - write end sets store flag and multi-function flag.
// - vector request only with all three enables and stack not full.
// - servicing clears only multi-function flag; software clears store flag.
// - read: set fetch enable, load address, set read strobe.
module ebac_top #(
	parameter logic [7:0] READ_CYCLES = ebac_pkg::READ_CYCLES_DEF,
	parameter logic [7:0] WRITE_TICKS = ebac_pkg::WRITE_TICKS_DEF,
	parameter logic [7:0] TICK_DIV    = ebac_pkg::TICK_DIV_DEF
) (
	input  wire logic                     clk,
	input  wire logic                     sys_rst,
	input  wire ebac_pkg::ebac_req_type     core_req,
	output logic [7:0]                    core_rdata,
	input  wire ebac_pkg::ebac_irq_ctl_type irq_ctl,
	output logic                          nvm_irq_flag,
	output logic                          mf_irq_flag,
	output logic                          irq_vector_req,
	output logic                          nvm_busy
);

	logic [ebac_pkg::NVM_DW-1:0] store_mem [ebac_pkg::NVM_DEPTH];

	ebac_pkg::ebac_state_type    state_r;
	logic [ebac_pkg::NVM_AW-1:0] nvm_address_r;
	logic [7:0]                  nvm_data_r;
	logic                        program_enable_r;
	logic                        fetch_enable_r;
	logic [7:0]                  pointer1_low_r;
	logic [7:0]                  pointer1_high_r;
	logic [7:0]                  pointer2_low_r;
	logic [7:0]                  pointer2_high_r;
	logic [ebac_pkg::NVM_AW-1:0] lat_addr_r;
	logic [7:0]                  lat_data_r;
	logic [7:0]                  cnt_r;
	logic                        nvm_irq_flag_r;
	logic                        mf_irq_flag_r;
	logic [7:0]                  rdata_r;
	logic                        tick;
	logic                        ptr1_hits;
	logic                        ptr2_hits;
	logic                        ctrl_sel;
	logic                        ctrl_wr;
	logic                        start_write;
	logic                        start_read;
	logic                        read_done;
	logic                        write_done;
	logic                        read_busy;
	logic                        write_busy;
	logic [7:0]                  ctrl_value;
	logic [7:0]                  rdata_nxt;

	ebac_slow_timer #(
		.TICK_DIV (TICK_DIV)
	) u_slow_timer (
		.clk     (clk),
		.sys_rst (sys_rst),
		.tick    (tick)
	);

	// the control register answers only when a pointer pair holds sector 1, 40H
	assign ptr1_hits = (pointer1_high_r == ebac_pkg::CTRL_SECTOR) && (pointer1_low_r == ebac_pkg::CTRL_LOW_ADDR);
	assign ptr2_hits = (pointer2_high_r == ebac_pkg::CTRL_SECTOR) && (pointer2_low_r == ebac_pkg::CTRL_LOW_ADDR);
	assign ctrl_sel  = ((core_req.addr == ebac_pkg::ADDR_INDIRECT1) && ptr1_hits)
	                || ((core_req.addr == ebac_pkg::ADDR_INDIRECT2) && ptr2_hits);
	assign ctrl_wr   = core_req.wr && ctrl_sel;

	assign read_busy  = (state_r == ebac_pkg::ST_READ);
	assign write_busy = (state_r == ebac_pkg::ST_WRITE);
	assign nvm_busy   = read_busy || write_busy;

	// enables are checked as they stood before this write, so both in one write start nothing
	assign start_write = ctrl_wr && core_req.wdata[ebac_pkg::CTRL_PROG_BIT] && program_enable_r
	                  && (state_r == ebac_pkg::ST_IDLE);
	// a write strobe wins if software breaks the one-strobe-at-a-time convention
	assign start_read  = ctrl_wr && core_req.wdata[ebac_pkg::CTRL_FETCH_BIT] && fetch_enable_r
	                  && (state_r == ebac_pkg::ST_IDLE) && !start_write;

	assign read_done  = read_busy && (cnt_r == READ_CYCLES - 8'h01);
	assign write_done = write_busy && tick && (cnt_r == WRITE_TICKS - 8'h01);

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			state_r <= ebac_pkg::ST_IDLE;
		end else begin
			case (state_r)
				ebac_pkg::ST_IDLE: begin
					if (start_write) begin
						state_r <= ebac_pkg::ST_WRITE;
					end else if (start_read) begin
						state_r <= ebac_pkg::ST_READ;
					end
				end
				ebac_pkg::ST_READ: begin
					if (read_done) begin
						state_r <= ebac_pkg::ST_IDLE;
					end
				end
				ebac_pkg::ST_WRITE: begin
					if (write_done) begin
						state_r <= ebac_pkg::ST_IDLE;
					end
				end
				default: begin
					state_r <= ebac_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// read counts clk cycles, write counts slow ticks
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			cnt_r <= ebac_pkg::RST_CNT;
		end else if (start_write || start_read || read_done || write_done) begin
			cnt_r <= ebac_pkg::RST_CNT;
		end else if (read_busy || (write_busy && tick)) begin
			cnt_r <= cnt_r + 8'h01;
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			lat_addr_r <= ebac_pkg::RST_ADDR;
			lat_data_r <= ebac_pkg::RST_BYTE;
		end else if (start_write || start_read) begin
			lat_addr_r <= nvm_address_r;
			lat_data_r <= nvm_data_r;
		end
	end

	// no reset: the array is the non-volatile content
	always_ff @(posedge clk) begin
		if (write_done) begin
			store_mem[lat_addr_r] <= lat_data_r;
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			program_enable_r <= 1'b0;
			fetch_enable_r   <= 1'b0;
		end else if (ctrl_wr) begin
			program_enable_r <= core_req.wdata[ebac_pkg::CTRL_PROG_EN_BIT];
			fetch_enable_r   <= core_req.wdata[ebac_pkg::CTRL_FETCH_EN_BIT];
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			pointer1_low_r  <= ebac_pkg::RST_BYTE;
			pointer1_high_r <= ebac_pkg::RST_BYTE;
			pointer2_low_r  <= ebac_pkg::RST_BYTE;
			pointer2_high_r <= ebac_pkg::RST_BYTE;
		end else if (core_req.wr) begin
			case (core_req.addr)
				ebac_pkg::ADDR_PTR1_LOW:  pointer1_low_r  <= core_req.wdata;
				ebac_pkg::ADDR_PTR1_HIGH: pointer1_high_r <= core_req.wdata;
				ebac_pkg::ADDR_PTR2_LOW:  pointer2_low_r  <= core_req.wdata;
				ebac_pkg::ADDR_PTR2_HIGH: pointer2_high_r <= core_req.wdata;
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			nvm_address_r <= ebac_pkg::RST_ADDR;
		end else if (core_req.wr && (core_req.addr == ebac_pkg::ADDR_NVM_ADDRESS)) begin
			nvm_address_r <= core_req.wdata[ebac_pkg::NVM_AW-1:0];
		end
	end

	// a finishing read wins over a core write in the same cycle
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			nvm_data_r <= ebac_pkg::RST_BYTE;
		end else if (read_done) begin
			nvm_data_r <= store_mem[lat_addr_r];
		end else if (core_req.wr && (core_req.addr == ebac_pkg::ADDR_NVM_DATA)) begin
			nvm_data_r <= core_req.wdata;
		end
	end

	// set wins over clear on both flags
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			nvm_irq_flag_r <= 1'b0;
			mf_irq_flag_r  <= 1'b0;
		end else begin
			if (write_done) begin
				nvm_irq_flag_r <= 1'b1;
			end else if (irq_ctl.nvm_irq_flag_clr) begin
				nvm_irq_flag_r <= 1'b0;
			end
			if (write_done) begin
				mf_irq_flag_r <= 1'b1;
			end else if (irq_ctl.mf_irq_service) begin
				mf_irq_flag_r <= 1'b0;
			end
		end
	end

	assign nvm_irq_flag   = nvm_irq_flag_r;
	assign mf_irq_flag    = mf_irq_flag_r;
	assign irq_vector_req = mf_irq_flag_r && nvm_irq_flag_r && irq_ctl.global_irq_enable
	                     && irq_ctl.mf_irq_enable && irq_ctl.nvm_irq_enable && !irq_ctl.stack_full;

	assign ctrl_value = {4'h0, program_enable_r, write_busy, fetch_enable_r, read_busy};

	always_comb begin
		rdata_nxt = ebac_pkg::RST_BYTE;
		case (core_req.addr)
			ebac_pkg::ADDR_INDIRECT1:   rdata_nxt = ptr1_hits ? ctrl_value : ebac_pkg::RST_BYTE;
			ebac_pkg::ADDR_INDIRECT2:   rdata_nxt = ptr2_hits ? ctrl_value : ebac_pkg::RST_BYTE;
			ebac_pkg::ADDR_PTR1_LOW:    rdata_nxt = pointer1_low_r;
			ebac_pkg::ADDR_PTR1_HIGH:   rdata_nxt = pointer1_high_r;
			ebac_pkg::ADDR_PTR2_LOW:    rdata_nxt = pointer2_low_r;
			ebac_pkg::ADDR_PTR2_HIGH:   rdata_nxt = pointer2_high_r;
			ebac_pkg::ADDR_NVM_ADDRESS: rdata_nxt = {2'b00, nvm_address_r};
			ebac_pkg::ADDR_NVM_DATA:    rdata_nxt = nvm_data_r;
			default:                    rdata_nxt = ebac_pkg::RST_BYTE;
		endcase
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			rdata_r <= ebac_pkg::RST_BYTE;
		end else if (core_req.rd) begin
			rdata_r <= rdata_nxt;
		end
	end

	assign core_rdata = rdata_r;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);

	a_addr_upper_zero: assert property (core_req.rd && (core_req.addr == ebac_pkg::ADDR_NVM_ADDRESS)
		|=> core_rdata[7:6] == 2'b00)
		else $error("address upper bits not zero");

	a_ctrl_needs_ptr: assert property (core_req.wr && !ctrl_sel && (state_r == ebac_pkg::ST_IDLE)
		|=> state_r == ebac_pkg::ST_IDLE)
		else $error("cycle started without pointer to control");

	a_prog_strobe_gate: assert property (ctrl_wr && core_req.wdata[ebac_pkg::CTRL_PROG_BIT] && !program_enable_r
		|=> state_r != ebac_pkg::ST_WRITE)
		else $error("write started with program enable clear");

	a_write_needs_en: assert property ($rose(write_busy) |-> $past(program_enable_r))
		else $error("write cycle without program enable");

	a_fetch_strobe_gate: assert property (ctrl_wr && core_req.wdata[ebac_pkg::CTRL_FETCH_BIT] && !fetch_enable_r
		|=> state_r != ebac_pkg::ST_READ)
		else $error("read started with fetch enable clear");

	a_read_needs_en: assert property ($rose(read_busy) |-> $past(fetch_enable_r))
		else $error("read cycle without fetch enable");

	a_write_ends: assert property ($rose(write_busy) |-> ##[2:1000] !write_busy)
		else $error("write strobe did not clear");

	a_read_len: assert property ($rose(read_busy) |-> read_busy [*4] ##1 !read_busy)
		else $error("read cycle length wrong");

	a_read_data: assert property ($fell(read_busy) |-> nvm_data_r == store_mem[$past(lat_addr_r)])
		else $error("fetched byte not in data register");

	a_data_hold: assert property (!nvm_busy && !$past(read_busy) && !(core_req.wr
		&& (core_req.addr == ebac_pkg::ADDR_NVM_DATA)) |=> $stable(nvm_data_r))
		else $error("data register changed while idle");

	a_latch_stable: assert property (write_busy && !start_write |=> $stable(lat_addr_r) && $stable(lat_data_r))
		else $error("latched address or data disturbed");

	a_write_flags: assert property ($fell(write_busy) |-> nvm_irq_flag_r && mf_irq_flag_r)
		else $error("write end did not raise flags");

	a_service_clear: assert property (irq_ctl.mf_irq_service && !write_done && nvm_irq_flag_r
		&& !irq_ctl.nvm_irq_flag_clr |=> !mf_irq_flag_r && nvm_irq_flag_r)
		else $error("service cleared the wrong flag");

	// a clear held across the write end must lose, or the end of the write goes unseen
	a_flag_set_wins: assert property (write_done && irq_ctl.nvm_irq_flag_clr |=> nvm_irq_flag_r)
		else $error("store flag clear beat write end");

	a_mf_set_wins: assert property (write_done && irq_ctl.mf_irq_service |=> mf_irq_flag_r)
		else $error("service beat write end");

	a_write_store: assert property (write_done |=> store_mem[$past(lat_addr_r)] == $past(lat_data_r))
		else $error("store byte not written");

	a_latch_start: assert property (start_write || start_read |=> lat_addr_r == $past(nvm_address_r)
		&& lat_data_r == $past(nvm_data_r))
		else $error("address or data not latched at start");

	a_read_keeps_latch: assert property (read_busy |=> $stable(lat_addr_r))
		else $error("latched address moved during read");

	a_write_keeps_data: assert property (write_busy && !(core_req.wr
		&& (core_req.addr == ebac_pkg::ADDR_NVM_DATA)) |=> $stable(nvm_data_r))
		else $error("data register changed during write");

	a_ptr1_hold: assert property (!(core_req.wr && (core_req.addr == ebac_pkg::ADDR_PTR1_HIGH))
		|=> $stable(pointer1_high_r))
		else $error("first pointer high byte moved");

	a_ptr2_hold: assert property (!(core_req.wr && (core_req.addr == ebac_pkg::ADDR_PTR2_HIGH))
		|=> $stable(pointer2_high_r))
		else $error("second pointer high byte moved");

	a_enable_update: assert property (ctrl_wr
		|=> program_enable_r == $past(core_req.wdata[ebac_pkg::CTRL_PROG_EN_BIT])
		&& fetch_enable_r == $past(core_req.wdata[ebac_pkg::CTRL_FETCH_EN_BIT]))
		else $error("enable bits not taken from control write");

	a_addr_write: assert property (core_req.wr && (core_req.addr == ebac_pkg::ADDR_NVM_ADDRESS)
		|=> nvm_address_r == $past(core_req.wdata[ebac_pkg::NVM_AW-1:0]))
		else $error("address register not loaded");

	c_write_cycle: cover property ($rose(write_busy) ##[1:1000] $fell(write_busy));
	c_read_cycle: cover property ($rose(read_busy) ##[1:8] $fell(read_busy));
	c_vector_req: cover property (irq_vector_req);
	c_blocked_write: cover property (ctrl_wr && core_req.wdata[ebac_pkg::CTRL_PROG_BIT] && !program_enable_r);
	c_set_wins: cover property (write_done && irq_ctl.nvm_irq_flag_clr);

endmodule : ebac_top

// >>> sim/testbench.sv
`timescale 1ns/100ps
module testbench;
	logic                       clk;
	logic                       sys_rst;
	ebac_pkg::ebac_req_type     core_req;
	logic [7:0]                 core_rdata;
	ebac_pkg::ebac_irq_ctl_type irq_ctl;
	logic                       nvm_irq_flag;
	logic                       mf_irq_flag;
	logic                       irq_vector_req;
	logic                       nvm_busy;
	logic                       rd_q;
	logic [7:0]                 exp_q[$];
	logic [31:0]                seed;
	logic [7:0]                 a_v;
	logic [7:0]                 d_v;
	int                         fail_count;
	int                         checks_done;

	// short write so the run stays brief; still long enough to overlap core traffic
	ebac_top #(
		.READ_CYCLES(8'h04),
		.WRITE_TICKS(8'h03),
		.TICK_DIV   (8'h04)
	) dut (
		.clk           (clk),
		.sys_rst       (sys_rst),
		.core_req      (core_req),
		.core_rdata    (core_rdata),
		.irq_ctl       (irq_ctl),
		.nvm_irq_flag  (nvm_irq_flag),
		.mf_irq_flag   (mf_irq_flag),
		.irq_vector_req(irq_vector_req),
		.nvm_busy      (nvm_busy)
	);

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp) begin
			fail_count++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task automatic finish_test;
		$display("checks=%0d mismatches=%0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : finish_test

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], 1'b0} ^ (s[31] ? 32'h04C11DB7 : 32'h00000000);
	endfunction : lfsr

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		core_req = '{a, 1'b1, 1'b0, d};
		@(negedge clk);
		core_req.wr = 1'b0;
	endtask : wr

	// expectation noted here, compared by the watcher one cycle later
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(negedge clk);
		core_req.addr = a;
		core_req.rd = 1'b1;
		exp_q.push_back(e);
		@(negedge clk);
		core_req.rd = 1'b0;
	endtask : rd

	task automatic wait_idle;
		int n;
		n = 0;
		while (nvm_busy !== 1'b0 && n < 400) begin
			@(negedge clk);
			n++;
		end
		if (n >= 400) begin
			fail_count++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, nvm_busy, 1'b0);
			finish_test();
		end
	endtask : wait_idle

	task automatic pulse_service(input logic mf, input logic nv);
		@(negedge clk);
		irq_ctl.mf_irq_service = mf;
		irq_ctl.nvm_irq_flag_clr = nv;
		@(negedge clk);
		irq_ctl.mf_irq_service = 1'b0;
		irq_ctl.nvm_irq_flag_clr = 1'b0;
	endtask : pulse_service

	task automatic endt(input string name);
		$display("test %s done", name);
	endtask : endt

	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst)
			rd_q <= 1'b0;
		else
			rd_q <= core_req.rd;
	end

	always @(negedge clk) begin
		if (rd_q) begin
			if (exp_q.size() == 0)
				check(core_rdata, 8'hEE);
			else
				check(core_rdata, exp_q.pop_front());
		end
	end

	initial begin
		sys_rst = 1'b1;
		core_req = '0;
		irq_ctl = '0;
		fail_count = 0;
		checks_done = 0;
		seed = 32'h4A77ADE9;
		repeat (3) @(negedge clk);
		sys_rst = 1'b0;
		rd(ebac_pkg::ADDR_NVM_ADDRESS, 8'h00);
		rd(ebac_pkg::ADDR_NVM_DATA, 8'h00);
		rd(ebac_pkg::ADDR_PTR1_HIGH, 8'h00);
		// pointer still in sector 0: this must not reach the control register
		wr(ebac_pkg::ADDR_INDIRECT1, 8'h0A);
		wr(ebac_pkg::ADDR_PTR1_LOW, 8'h40);
		wr(ebac_pkg::ADDR_PTR1_HIGH, 8'h01);
		wr(ebac_pkg::ADDR_PTR2_LOW, 8'h40);
		wr(ebac_pkg::ADDR_PTR2_HIGH, 8'h01);
		rd(ebac_pkg::ADDR_INDIRECT1, 8'h00);
		wr(ebac_pkg::ADDR_NVM_ADDRESS, 8'hFF);
		rd(ebac_pkg::ADDR_NVM_ADDRESS, 8'h3F);
		endt("reset");
		wr(ebac_pkg::ADDR_INDIRECT1, 8'h04);
		check(nvm_busy, 8'h00);
		wr(ebac_pkg::ADDR_INDIRECT1, 8'h0C);
		check(nvm_busy, 8'h00);
		rd(ebac_pkg::ADDR_INDIRECT1, 8'h08);
		wr(ebac_pkg::ADDR_INDIRECT1, 8'h01);
		check(nvm_busy, 8'h00);
		wr(ebac_pkg::ADDR_INDIRECT1, 8'h03);
		check(nvm_busy, 8'h00);
		rd(ebac_pkg::ADDR_INDIRECT1, 8'h02);
		endt("gating");
		wr(ebac_pkg::ADDR_NVM_ADDRESS, 8'h15);
		wr(ebac_pkg::ADDR_NVM_DATA, 8'hA6);
		wr(ebac_pkg::ADDR_INDIRECT1, 8'h08);
		wr(ebac_pkg::ADDR_INDIRECT1, 8'h0C);
		check(nvm_busy, 8'h01);
		rd(ebac_pkg::ADDR_INDIRECT1, 8'h0C);
		wr(ebac_pkg::ADDR_NVM_ADDRESS, 8'h2A);
		wr(ebac_pkg::ADDR_NVM_DATA, 8'h59);
		check(nvm_busy, 8'h01);
		wait_idle();
		rd(ebac_pkg::ADDR_INDIRECT1, 8'h08);
		check(nvm_irq_flag, 8'h01);
		check(mf_irq_flag, 8'h01);
		wr(ebac_pkg::ADDR_INDIRECT1, 8'h02);
		wr(ebac_pkg::ADDR_NVM_ADDRESS, 8'h15);
		wr(ebac_pkg::ADDR_INDIRECT1, 8'h03);
		check(nvm_busy, 8'h01);
		rd(ebac_pkg::ADDR_INDIRECT1, 8'h03);
		wait_idle();
		rd(ebac_pkg::ADDR_INDIRECT1, 8'h02);
		rd(ebac_pkg::ADDR_NVM_DATA, 8'hA6);
		// enables act on their old value, so drop fetch enable first
		wr(ebac_pkg::ADDR_INDIRECT1, 8'h00);
		wr(ebac_pkg::ADDR_INDIRECT1, 8'h01);
		check(nvm_busy, 8'h00);
		rd(ebac_pkg::ADDR_NVM_DATA, 8'hA6);
		endt("write_read");
		@(negedge clk);
		irq_ctl.global_irq_enable = 1'b1;
		irq_ctl.mf_irq_enable = 1'b1;
		irq_ctl.nvm_irq_enable = 1'b1;
		@(negedge clk);
		check(irq_vector_req, 8'h01);
		irq_ctl.stack_full = 1'b1;
		@(negedge clk);
		check(irq_vector_req, 8'h00);
		irq_ctl.stack_full = 1'b0;
		irq_ctl.global_irq_enable = 1'b0;
		@(negedge clk);
		check(irq_vector_req, 8'h00);
		irq_ctl.global_irq_enable = 1'b1;
		pulse_service(1'b1, 1'b0);
		check(mf_irq_flag, 8'h00);
		check(nvm_irq_flag, 8'h01);
		check(irq_vector_req, 8'h00);
		pulse_service(1'b0, 1'b1);
		check(nvm_irq_flag, 8'h00);
		endt("interrupt");
		// random bytes through the second pointer pair
		for (int i = 0; i < 4; i++) begin
			seed = lfsr(seed);
			a_v = {2'b00, seed[5:0]};
			d_v = seed[15:8];
			wr(ebac_pkg::ADDR_NVM_ADDRESS, a_v);
			wr(ebac_pkg::ADDR_NVM_DATA, d_v);
			irq_ctl.global_irq_enable = 1'b0;
			wr(ebac_pkg::ADDR_INDIRECT2, 8'h08);
			wr(ebac_pkg::ADDR_INDIRECT2, 8'h0C);
			irq_ctl.global_irq_enable = 1'b1;
			// clears held across the write end: the set must win
			irq_ctl.nvm_irq_flag_clr = 1'b1;
			irq_ctl.mf_irq_service = 1'b1;
			wait_idle();
			check(nvm_irq_flag, 8'h01);
			check(mf_irq_flag, 8'h01);
			irq_ctl.nvm_irq_flag_clr = 1'b0;
			irq_ctl.mf_irq_service = 1'b0;
			wr(ebac_pkg::ADDR_NVM_DATA, ~d_v);
			wr(ebac_pkg::ADDR_INDIRECT2, 8'h00);
			wr(ebac_pkg::ADDR_INDIRECT2, 8'h04);
			check(nvm_busy, 8'h00);
			wr(ebac_pkg::ADDR_INDIRECT2, 8'h02);
			wr(ebac_pkg::ADDR_INDIRECT2, 8'h03);
			wait_idle();
			rd(ebac_pkg::ADDR_NVM_DATA, d_v);
		end
		endt("random");
		repeat (2) @(negedge clk);
		finish_test();
	end
endmodule : testbench
